// ==== hdl/sfs_defines.svh ====
// constants of the set-file / rotate / sleep execution unit
// assumes: 16-bit program words, 8-bit data path, 12-bit data address
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH

// opcode fields
`define SFS_ROT_PREFIX 6'h10
`define SFS_ROT_MSB 15
`define SFS_ROT_LSB 10
`define SFS_FILL_PREFIX 7'h34
`define SFS_FILL_LSB 9
`define SFS_SLEEP_WORD 16'h0003
`define SFS_DEST_BIT 9
`define SFS_ACCESS_BIT 8

// data values
`define SFS_ALL_ONES 8'hFF
`define SFS_ACCESS_SPLIT 8'h80
`define SFS_ACCESS_LOW_BANK 4'h0
`define SFS_ACCESS_HIGH_BANK 4'hF

// reset values of the power flags and the working register
`define SFS_PWRDN_RESET 1'b1
`define SFS_TIMEOUT_RESET 1'b1
`define SFS_W_RESET 8'h00

`endif

// ==== hdl/sfs_pkg.sv ====
// types of the set-file / rotate / sleep execution unit
// assumes: sfs_defines.svh holds all numeric constants
package sfs_pkg;
    typedef enum logic [1:0] {
        SFS_Q1,
        SFS_Q2,
        SFS_Q3,
        SFS_Q4
    } sfs_phase_e;

    typedef enum logic [1:0] {
        SFS_OP_NONE,
        SFS_OP_ROT,
        SFS_OP_FILL,
        SFS_OP_SLEEP
    } sfs_op_e;
endpackage : sfs_pkg

// ==== hdl/sfs_exec.sv ====
// execution of rotate-right-no-carry, set-file and sleep in four phases
// assumes: fetch presents instr_word while q_phase is Q1 and the core is
// awake; data memory answers a read one clock after dm_rd, same clock
`include "sfs_defines.svh"
`timescale 1ns/1ns
`default_nettype none

// Function
// - rotate right without carry moves every bit one place lower and bit 0 to bit 7, leaving the source alone when the result goes to the working register.
// - the destination bit sends the result to the working register when 0 and back to the file register when 1.
// - set-file writes all ones into the addressed data byte regardless of its old value.
// - set-file is decoded from one 16-bit word with a 7-bit prefix, one bank-access bit and an 8-bit file address.
// - with the bank-access bit at 0 the byte is taken from the access bank, ignoring the bank select register.
// - with the bank-access bit at 1 the byte lies in the bank named by the bank select register.
// - sleep clears the power-down flag, sets the time-out flag, clears the watchdog timer, then stops the oscillator.
// - a wake-up caused by the watchdog clears the time-out flag.
module sfs_exec
    import sfs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] instr_word,
    input wire logic [3:0] bank_select_register,
    input wire logic [7:0] dm_rdata,
    input wire logic wake_watchdog,
    input wire logic wake_other,
    output sfs_phase_e q_phase,
    output logic [11:0] dm_addr,
    output logic dm_rd,
    output logic dm_wr,
    output logic [7:0] dm_wdata,
    output logic [7:0] work_reg,
    output logic status_n,
    output logic status_z,
    output logic power_down_flag,
    output logic time_out_flag,
    output logic watchdog_timer_clear,
    output logic osc_stopped
);

    function automatic sfs_op_e decode_op(input logic [15:0] w);
        if (w == `SFS_SLEEP_WORD)
            decode_op = SFS_OP_SLEEP;
        else if (w[15:`SFS_FILL_LSB] == `SFS_FILL_PREFIX)
            decode_op = SFS_OP_FILL;
        else if (w[`SFS_ROT_MSB:`SFS_ROT_LSB] == `SFS_ROT_PREFIX)
            decode_op = SFS_OP_ROT;
        else
            decode_op = SFS_OP_NONE;
    endfunction : decode_op

    function automatic logic [11:0] bank_addr(input logic a,
                                              input logic [7:0] f,
                                              input logic [3:0] bank);
        if (a)
            bank_addr = {bank, f};
        else if (f < `SFS_ACCESS_SPLIT)
            bank_addr = {`SFS_ACCESS_LOW_BANK, f};
        else
            bank_addr = {`SFS_ACCESS_HIGH_BANK, f};
    endfunction : bank_addr

    function automatic logic [7:0] rot_right(input logic [7:0] v);
        rot_right = {v[0], v[7:1]};
    endfunction : rot_right

    sfs_op_e op_reg;
    logic dest_reg;
    logic [7:0] result_reg;
    sfs_op_e op_next;

    assign op_next = decode_op(instr_word);

    // phase sequencer, frozen in Q1 while the oscillator is stopped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q_phase <= SFS_Q1;
        end else if (!osc_stopped) begin
            unique case (q_phase)
                SFS_Q1: q_phase <= SFS_Q2;
                SFS_Q2: q_phase <= SFS_Q3;
                SFS_Q3: q_phase <= SFS_Q4;
                SFS_Q4: q_phase <= SFS_Q1;
            endcase
        end
    end

    // decode in Q1 and address the operand for Q2
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            op_reg <= SFS_OP_NONE;
            dest_reg <= 1'b0;
            dm_addr <= 12'h000;
        end else if (q_phase == SFS_Q1 && !osc_stopped) begin
            op_reg <= op_next;
            dest_reg <= instr_word[`SFS_DEST_BIT];
            dm_addr <= bank_addr(instr_word[`SFS_ACCESS_BIT],
                                 instr_word[7:0], bank_select_register);
        end
    end

    // read strobe stands in Q2; set-file needs no operand but a read is
    // harmless and keeps the data path identical for both
    always_ff @(posedge clk_sys) begin
        if (rst)
            dm_rd <= 1'b0;
        else
            dm_rd <= q_phase == SFS_Q1 && !osc_stopped &&
                     (op_next == SFS_OP_ROT || op_next == SFS_OP_FILL);
    end

    // process data in Q3
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result_reg <= 8'h00;
        end else if (q_phase == SFS_Q3) begin
            if (op_reg == SFS_OP_FILL)
                result_reg <= `SFS_ALL_ONES;
            else
                result_reg <= rot_right(dm_rdata);
        end
    end

    // status: only the rotate touches n and z
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_n <= 1'b0;
            status_z <= 1'b0;
        end else if (q_phase == SFS_Q3 && op_reg == SFS_OP_ROT) begin
            status_n <= dm_rdata[0];
            status_z <= dm_rdata == 8'h00;
        end
    end

    // write to destination in Q4
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dm_wr <= 1'b0;
            dm_wdata <= 8'h00;
        end else begin
            dm_wr <= q_phase == SFS_Q3 && (op_reg == SFS_OP_FILL ||
                     (op_reg == SFS_OP_ROT && dest_reg));
            if (q_phase == SFS_Q3)
                dm_wdata <= op_reg == SFS_OP_FILL ? `SFS_ALL_ONES
                                                  : rot_right(dm_rdata);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            work_reg <= `SFS_W_RESET;
        else if (q_phase == SFS_Q3 && op_reg == SFS_OP_ROT && !dest_reg)
            work_reg <= rot_right(dm_rdata);
    end

    // power flags: the wake edge and the sleep entry never meet, as wake
    // is only honoured while the oscillator is stopped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            power_down_flag <= `SFS_PWRDN_RESET;
            time_out_flag <= `SFS_TIMEOUT_RESET;
        end else if (q_phase == SFS_Q3 && op_reg == SFS_OP_SLEEP) begin
            power_down_flag <= 1'b0;
            time_out_flag <= 1'b1;
        end else if (osc_stopped && wake_watchdog) begin
            time_out_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            watchdog_timer_clear <= 1'b0;
        else
            watchdog_timer_clear <= q_phase == SFS_Q3 &&
                                    op_reg == SFS_OP_SLEEP;
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            osc_stopped <= 1'b0;
        else if (osc_stopped && (wake_watchdog || wake_other))
            osc_stopped <= 1'b0;
        else if (q_phase == SFS_Q4 && op_reg == SFS_OP_SLEEP)
            osc_stopped <= 1'b1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_sleep_taken;
        q_phase == SFS_Q1 && !osc_stopped && instr_word == `SFS_SLEEP_WORD;
    endsequence

    sequence s_sleep_done;
        ##3 (!power_down_flag && time_out_flag && watchdog_timer_clear)
        ##1 osc_stopped;
    endsequence

    chk_rotate_write_value: assert property (
        dm_wr && op_reg == SFS_OP_ROT |->
            dm_wdata == rot_right($past(dm_rdata)))
        else $error("rotate result written wrong");

    chk_rotate_w_keep: assert property (
        q_phase == SFS_Q4 && op_reg == SFS_OP_ROT && !dest_reg |-> !dm_wr)
        else $error("source byte written on w destination");

    chk_dest_w_value: assert property (
        q_phase == SFS_Q4 && op_reg == SFS_OP_ROT && !dest_reg |->
            work_reg == rot_right($past(dm_rdata)))
        else $error("working register not loaded");

    chk_fill_all_ones: assert property (
        q_phase == SFS_Q4 && op_reg == SFS_OP_FILL |->
            dm_wr && dm_wdata == `SFS_ALL_ONES)
        else $error("set-file did not write all ones");

    chk_fill_decode: assert property (
        q_phase == SFS_Q1 && !osc_stopped &&
        instr_word[15:`SFS_FILL_LSB] == `SFS_FILL_PREFIX |=>
            op_reg == SFS_OP_FILL ##1 dm_rd == 1'b0)
        else $error("set-file not decoded");

    chk_access_bank: assert property (
        q_phase == SFS_Q1 && !osc_stopped &&
        !instr_word[`SFS_ACCESS_BIT] && instr_word[7] == 1'b0 |=>
            dm_addr == {`SFS_ACCESS_LOW_BANK, $past(instr_word[7:0])})
        else $error("access bank address wrong");

    chk_bsr_bank: assert property (
        q_phase == SFS_Q1 && !osc_stopped && instr_word[`SFS_ACCESS_BIT] |=>
            dm_addr == {$past(bank_select_register), $past(instr_word[7:0])})
        else $error("banked address wrong");

    chk_sleep_entry: assert property (
        s_sleep_taken |-> s_sleep_done)
        else $error("sleep side effects wrong");

    chk_wdt_wake: assert property (
        osc_stopped && wake_watchdog |=> !time_out_flag && !osc_stopped)
        else $error("watchdog wake did not clear time-out");

    chk_fill_status: assert property (
        q_phase == SFS_Q4 && op_reg == SFS_OP_FILL |->
            $stable(status_n) && $stable(status_z) ##1 q_phase == SFS_Q1)
        else $error("set-file touched status or overran");

    // a skipped phase would let a write land before its read
    sequence s_rest_of_cycle;
        q_phase == SFS_Q2 ##1 q_phase == SFS_Q3 ##1 q_phase == SFS_Q4;
    endsequence

    chk_four_phases: assert property (
        q_phase == SFS_Q1 && !osc_stopped |=> s_rest_of_cycle)
        else $error("instruction cycle not four phases");

    chk_rd_pulse: assert property (
        dm_rd |-> q_phase == SFS_Q2 ##1 !dm_rd)
        else $error("read strobe outside q2");

    chk_wr_pulse: assert property (
        dm_wr |-> q_phase == SFS_Q4 ##1 !dm_wr)
        else $error("write strobe outside q4");

    chk_wdt_clear_pulse: assert property (
        watchdog_timer_clear |-> q_phase == SFS_Q4 && op_reg == SFS_OP_SLEEP)
        else $error("watchdog cleared outside sleep");

    chk_sleep_frozen: assert property (
        osc_stopped && !wake_watchdog && !wake_other |=>
            osc_stopped && q_phase == SFS_Q1)
        else $error("core ran while asleep");

    chk_other_wake: assert property (
        osc_stopped && wake_other && !wake_watchdog |=>
            !osc_stopped && $stable(time_out_flag))
        else $error("other wake source touched time-out");

    chk_rotate_status: assert property (
        q_phase == SFS_Q4 && op_reg == SFS_OP_ROT |->
            status_n == $past(dm_rdata[0]) &&
            status_z == ($past(dm_rdata) == 8'h00))
        else $error("rotate status wrong");

    chk_dest_file: assert property (
        q_phase == SFS_Q4 && op_reg == SFS_OP_ROT && dest_reg |->
            dm_wr && $stable(work_reg))
        else $error("file destination not written");

    chk_fill_keeps_w: assert property (
        q_phase == SFS_Q4 && op_reg == SFS_OP_FILL |-> $stable(work_reg))
        else $error("set-file touched working register");

    chk_sleep_no_write: assert property (
        q_phase == SFS_Q4 && op_reg == SFS_OP_SLEEP |->
            !dm_wr && $stable(work_reg))
        else $error("sleep wrote data");

    // upper half of the access bank maps onto the top bank
    chk_access_high: assert property (
        q_phase == SFS_Q1 && !osc_stopped &&
        !instr_word[`SFS_ACCESS_BIT] && instr_word[7] |=>
            dm_addr == {`SFS_ACCESS_HIGH_BANK, $past(instr_word[7:0])})
        else $error("upper access bank address wrong");

endmodule : sfs_exec

`default_nettype wire

// ==== tb/sfs_exec_tb.sv ====
// bench of the rotate / set-file / sleep unit: memory and wake sources
// assumes: sfs_exec alone on one clock, memory answers the cycle after dm_rd
`include "sfs_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module sfs_exec_tb
    import sfs_pkg::*;
;
    typedef struct packed {
        logic rd, wr, n, z, pwr, to, wc;
        logic [11:0] a;
        logic [7:0] d, w;
    } sfs_note_s;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0] bank_select_register = 4'h0;
    logic [7:0] dm_rdata = 8'h00;
    logic wake_watchdog = 1'b0;
    logic wake_other = 1'b0;
    sfs_phase_e q_phase;
    logic [11:0] dm_addr;
    logic dm_rd, dm_wr, status_n, status_z, power_down_flag, time_out_flag;
    logic watchdog_timer_clear, osc_stopped;
    logic [7:0] dm_wdata, work_reg, ew = 8'h00;
    logic [7:0] mem [4096];
    logic [7:0] shadow [4096];
    logic en = 1'b0, ez = 1'b0, epd = 1'b1, eto = 1'b1;
    sfs_note_s notes [$];
    sfs_note_s nt;
    int err_total = 0, checked = 0, seed = 31;

    sfs_exec sfs_exec_inst (.clk_sys(clk_sys), .rst(rst),
        .instr_word(instr_word), .bank_select_register(bank_select_register),
        .dm_rdata(dm_rdata), .wake_watchdog(wake_watchdog),
        .wake_other(wake_other), .q_phase(q_phase), .dm_addr(dm_addr),
        .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata),
        .work_reg(work_reg), .status_n(status_n), .status_z(status_z),
        .power_down_flag(power_down_flag), .time_out_flag(time_out_flag),
        .watchdog_timer_clear(watchdog_timer_clear),
        .osc_stopped(osc_stopped));

    always #2 clk_sys = ~clk_sys;

    // read data toggles outside the answer cycle so a stale byte never passes
    always @(posedge clk_sys) begin
        if (dm_wr === 1'b1) begin
            mem[dm_addr] <= dm_wdata;
        end
        if (dm_rd === 1'b1) begin
            dm_rdata <= mem[dm_addr];
        end else begin
            dm_rdata <= ~dm_rdata;
        end
    end

    task automatic cmp(input string nm, input logic [11:0] e,
                       input logic [11:0] s);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp

    task automatic end_of_test;
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    always @(negedge clk_sys) begin
        if (rst === 1'b0 && q_phase === SFS_Q4 && notes.size() > 0) begin
            nt = notes.pop_front();
            cmp("dm_wr", 12'(nt.wr), 12'(dm_wr));
            if (nt.rd) cmp("dm_addr", nt.a, dm_addr);
            if (nt.wr) cmp("dm_wdata", 12'(nt.d), 12'(dm_wdata));
            cmp("work_reg", 12'(nt.w), 12'(work_reg));
            cmp("status", 12'({nt.n, nt.z}), 12'({status_n, status_z}));
            cmp("flags", 12'({nt.pwr, nt.to, nt.wc}), 12'({power_down_flag,
                time_out_flag, watchdog_timer_clear}));
        end
    end

    // the note is queued at the edge that takes the word
    task automatic issue(input logic [15:0] wd, input logic [3:0] bk,
                         input sfs_note_s e);
        int i;
        instr_word <= wd;
        bank_select_register <= bk;
        for (i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            if (q_phase === SFS_Q1 && osc_stopped === 1'b0) break;
        end
        if (i == 40) begin
            err_total++;
            end_of_test();
        end
        notes.push_back(e);
    endtask : issue

    // kind: 0 rotate, 1 set-file, 2 sleep, 3 and 4 near-miss words
    task automatic run_op(input int kind, input logic d, input logic a,
                          input logic [7:0] f, input logic [3:0] bk);
        sfs_note_s e;
        logic [11:0] ad;
        logic [7:0] r;
        logic [15:0] wd;
        ad = a ? {bk, f} : (f < 8'h80 ? {4'h0, f} : {4'hF, f});
        r = {shadow[ad][0], shadow[ad][7:1]};
        e = '0;
        wd = (kind == 3) ? {7'h35, a, f} : 16'h0002;
        if (kind == 0) begin
            wd = {`SFS_ROT_PREFIX, d, a, f};
            en = r[7];
            ez = (r == 8'h00);
            if (d) shadow[ad] = r;
            else ew = r;
            e.rd = 1'b1;
            e.wr = d;
            e.d = r;
        end else if (kind == 1) begin
            wd = {`SFS_FILL_PREFIX, a, f};
            shadow[ad] = `SFS_ALL_ONES;
            e.rd = 1'b1;
            e.wr = 1'b1;
            e.d = 8'hFF;
        end else if (kind == 2) begin
            wd = `SFS_SLEEP_WORD;
            epd = 1'b0;
            eto = 1'b1;
            e.wc = 1'b1;
        end
        e.a = ad;
        e.w = ew;
        e.n = en;
        e.z = ez;
        e.pwr = epd;
        e.to = eto;
        issue(wd, bk, e);
    endtask : run_op

    task automatic do_sleep(input logic by_wd);
        int i;
        run_op(2, 1'b0, 1'b0, 8'h00, 4'h0);
        for (i = 0; i < 20 && osc_stopped !== 1'b1; i++) @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        cmp("sleep", 12'({osc_stopped, q_phase}), 12'({1'b1, SFS_Q1}));
        @(posedge clk_sys);
        wake_watchdog <= by_wd;
        wake_other <= ~by_wd;
        @(posedge clk_sys);
        wake_watchdog <= 1'b0;
        wake_other <= 1'b0;
        instr_word <= 16'h0000;
        eto = ~by_wd;
        @(negedge clk_sys);
        cmp("osc_stopped", 12'(osc_stopped), 12'h000);
        cmp("time_out_flag", 12'(time_out_flag), 12'(eto));
        @(posedge clk_sys);
    endtask : do_sleep

    initial begin
        int i;
        logic [31:0] v;
        for (i = 0; i < 4096; i++) begin
            v = $random(seed);
            mem[i] = v[7:0];
            shadow[i] = v[7:0];
        end
        mem[12'h5AA] = 8'hD7;
        shadow[12'h5AA] = 8'hD7;
        mem[12'h020] = 8'h00;
        shadow[12'h020] = 8'h00;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        run_op(0, 1'b0, 1'b1, 8'hAA, 4'h5);
        run_op(0, 1'b1, 1'b1, 8'hAA, 4'h5);
        run_op(1, 1'b0, 1'b1, 8'hAA, 4'h5);
        run_op(0, 1'b0, 1'b1, 8'hAA, 4'h5);
        run_op(0, 1'b0, 1'b0, 8'h20, 4'h9);
        run_op(1, 1'b0, 1'b0, 8'h7F, 4'h9);
        run_op(0, 1'b1, 1'b0, 8'h80, 4'h9);
        for (i = 0; i < 80; i++) begin
            v = $random(seed);
            run_op(v[1:0] == 2'h2 ? 4 : v[1:0], v[2], v[3], v[11:4], v[15:12]);
        end
        do_sleep(1'b1);
        do_sleep(1'b0);
        run_op(2, 1'b0, 1'b0, 8'h00, 4'h0);
        repeat (10) @(posedge clk_sys);
        rst <= 1'b1;
        instr_word <= 16'h0000;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        cmp("after reset", 12'({osc_stopped, power_down_flag, time_out_flag}),
            12'h003);
        {ew, en, ez, epd, eto} = {8'h00, 4'h3};
        @(posedge clk_sys);
        run_op(1, 1'b0, 1'b1, 8'h33, 4'hC);
        repeat (8) @(posedge clk_sys);
        cmp("pending notes", 12'(notes.size()), 12'h000);
        end_of_test();
    end
endmodule : sfs_exec_tb
`default_nettype wire
